/* File: hw/fce_flash_cmd_error_security.v */
// Flash command sequence checker, launch control and security state
// ==========================================================
// Notes on behaviour
// - Array write before clock divider is loaded sets access error, aborts.
// - Array write while buffer empty flag clear sets access error, aborts.
// - Program block writes must be 32-bit, data block writes 16-bit.
// - After block 0 even word, only block 0 odd or block 1 odd may follow.
// - A second data block half word in one sequence is an access error.
// - Program plus data block in one sequence errors unless mass erase/blank check.
// - Unknown command code written to command register is an access error.
// - After an array write, any register write except command is an error.
// - A second command before launch is an access error.
// - After command, only the status write clearing buffer empty is allowed.
// - Writing zero to buffer empty before launch aborts with access error.
// - Program/page erase to protected sector or mass erase under protection: violation.
// - Array read during active command gives undefined data, no access error.
// - Halt with active command aborts, drops high voltage, sets complete and error.
// - Halt with no command active leaves access error unchanged.
// - Security word loaded into security register after each reset.
// - After mass erase or page 0 erase, report secured until register written with the open field, a blank check passes or the backdoor key matches.
// - Key access bit, keys at 0x0400 then 0x0404, match clears secured until reset.
// - All-zero or all-ones key locks backdoor until reset.
// - Backdoor unlock leaves stored security word and protections untouched.
// - Passing full blank check unsecures; reset returns to security word.
// - Codes 0x40, 0x41, 0x65 are valid commands.
`timescale 1ns/1ps
`default_nettype none
`include "fce_consts.vh"

module fce_flash_cmd_error_security #(
  parameter AW = 20,
  parameter NSECT = 8,
  parameter [31:0] SEC_WORD_DFLT = 32'h0000_0000,
  parameter [63:0] KEY_DFLT = 64'h0123_4567_89ab_cdef
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire arr_wr,
  input wire arr_rd,
  input wire [AW-1:0] arr_addr,
  input wire arr_is_data,
  input wire [1:0] arr_size,
  input wire [31:0] arr_wdata,
  output reg [31:0] arr_rdata,
  input wire halt_req,
  output reg hv_en,
  output reg secured
);

  // ==========================================================
  // State
  // Sequence progress: idle, array written, command written
  localparam S_IDLE = 2'h0;
  localparam S_ARR = 2'h1;
  localparam S_CMD = 2'h2;

  reg [1:0] seq_r;
  reg access_error_flag_r, protection_violation_flag_r, command_buffer_empty_flag_r, command_complete_flag_r, blank_ok_r;
  reg clkd_ld_r;
  reg [7:0] clkd_r;
  reg [7:0] cmd_r, run_cmd_r;
  reg key_access_bit_r;
  reg [NSECT-1:0] prot_r;
  reg [31:0] sec_r;
  reg sec_ld_r;
  reg secured_status_bit_r;
  reg forced_sec_r;
  reg key_lock_r;
  reg key0_ok_r, key0_seen_r;
  reg seq_prog_r, seq_data_r, seq_b0e_r, seq_extra_r, seq_page0_r, seq_prot_r;
  reg [15:0] op_cnt_r;
  reg halt_q_r;
  // Backdoor key held in flops, since no array is modelled here
  reg [63:0] key_mem_r;

  wire [2:0] sect = arr_addr[AW-1 -: 3];
  // Halt is a level; only its rising edge counts as entry
  wire halt_rise = halt_req & ~halt_q_r;
  wire cmd_active = ~command_complete_flag_r;

  function valid_cmd;
    input [7:0] c;
    begin
      valid_cmd = (c == `FCE_CMD_PERASE) | (c == `FCE_CMD_MERASE) | (c == `FCE_CMD_SIG) |
                  (c == `FCE_CMD_PROG) | (c == `FCE_CMD_BLANK);
    end
  endfunction

  function is_bad_key;
    input [31:0] k;
    begin
      is_bad_key = (k == 32'h0000_0000) | (k == 32'hffff_ffff);
    end
  endfunction

  // Array write errors, combined
  reg arr_err;
  always @* begin
    arr_err = 1'b0;
    if (!clkd_ld_r) arr_err = 1'b1;
    if (!command_buffer_empty_flag_r) arr_err = 1'b1;
    if (!arr_is_data && arr_size != `FCE_SIZE_W) arr_err = 1'b1;
    if (arr_is_data && arr_size != `FCE_SIZE_H) arr_err = 1'b1;
    if (seq_r == S_ARR) begin
      if (arr_is_data && seq_data_r) arr_err = 1'b1;
      if (!arr_is_data && seq_prog_r) begin
        if (!seq_b0e_r || seq_extra_r || !arr_addr[`FCE_ODD_BIT]) arr_err = 1'b1;
      end
    end
    if (seq_r == S_CMD) arr_err = 1'b1;
  end

  // protection decode for the code being written
  wire [7:0] new_cmd = reg_wdata[7:0];
  wire prot_hit = ((new_cmd == `FCE_CMD_PROG || new_cmd == `FCE_CMD_PERASE) && seq_prot_r) ||
                  (new_cmd == `FCE_CMD_MERASE && |prot_r);

  wire key_access_bit_wr = arr_wr & key_access_bit_r;
  wire cmd_wr = reg_wr & (reg_addr == `FCE_A_CMD);
  wire ustat_wr = reg_wr & (reg_addr == `FCE_A_USTAT);

  // ==========================================================
  // Main sequencer
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      seq_r <= S_IDLE;
      access_error_flag_r <= 1'b0;
      protection_violation_flag_r <= 1'b0;
      command_buffer_empty_flag_r <= 1'b1;
      command_complete_flag_r <= 1'b1;
      blank_ok_r <= 1'b0;
      clkd_ld_r <= 1'b0;
      clkd_r <= 8'h00;
      cmd_r <= 8'h00;
      run_cmd_r <= 8'h00;
      key_access_bit_r <= 1'b0;
      prot_r <= {NSECT{1'b0}};
      sec_r <= 32'h0000_0000;
      sec_ld_r <= 1'b1;
      secured_status_bit_r <= 1'b1;
      forced_sec_r <= 1'b0;
      key_lock_r <= 1'b0;
      key0_ok_r <= 1'b0;
      key0_seen_r <= 1'b0;
      seq_prog_r <= 1'b0;
      seq_data_r <= 1'b0;
      seq_b0e_r <= 1'b0;
      seq_extra_r <= 1'b0;
      seq_page0_r <= 1'b0;
      seq_prot_r <= 1'b0;
      op_cnt_r <= 16'h0000;
      halt_q_r <= 1'b0;
      hv_en <= 1'b0;
      key_mem_r <= KEY_DFLT;
    end else begin
      halt_q_r <= halt_req;
      // security word loaded after reset
      // Secured from reset on, so there is no open window before the load
      if (sec_ld_r) begin
        sec_ld_r <= 1'b0;
        sec_r <= SEC_WORD_DFLT;
        secured_status_bit_r <= (SEC_WORD_DFLT[`FCE_SECF_HI:`FCE_SECF_LO] != `FCE_SECF_OPEN);
      end
      // Running operation model: fixed time
      // Stands in for the real algorithms; run length does not depend on the command
      if (cmd_active && !halt_rise) begin
        if (op_cnt_r == `FCE_OP_CYC) begin
          command_complete_flag_r <= 1'b1;
          command_buffer_empty_flag_r <= 1'b1;
          hv_en <= 1'b0;
          op_cnt_r <= 16'h0000;
          if (run_cmd_r == `FCE_CMD_MERASE || (run_cmd_r == `FCE_CMD_PERASE && seq_page0_r)) begin
            forced_sec_r <= 1'b1;
            secured_status_bit_r <= 1'b1;
          end
          if (run_cmd_r == `FCE_CMD_BLANK && blank_ok_r) secured_status_bit_r <= 1'b0;
        end else begin
          op_cnt_r <= op_cnt_r + 16'h0001;
        end
      end
      if (halt_rise && cmd_active) begin
        command_complete_flag_r <= 1'b1;
        command_buffer_empty_flag_r <= 1'b1;
        access_error_flag_r <= 1'b1;
        hv_en <= 1'b0;
        op_cnt_r <= 16'h0000;
        seq_r <= S_IDLE;
      end
      // halt when idle leaves flags alone
      // Only the edge detector sees an idle halt
      // ----- Backdoor key path -----
      if (key_access_bit_wr) begin
        // trivial keys lock backdoor
        // Lock persists until reset, so no key pair after a trivial key can unlock
        if (is_bad_key(arr_wdata)) key_lock_r <= 1'b1;
        else if (arr_addr == `FCE_KEY0_OFS) begin
          key0_seen_r <= 1'b1;
          key0_ok_r <= (arr_wdata == key_mem_r[63:32]);
        end else if (arr_addr == `FCE_KEY1_OFS && key0_seen_r) begin
          // Second key word counts only after the first; order is part of the key
          key0_seen_r <= 1'b0;
          if (key0_ok_r && arr_wdata == key_mem_r[31:0] && !key_lock_r &&
              sec_r[`FCE_BACKDOOR_ENABLE_FIELD_HI:`FCE_BACKDOOR_ENABLE_FIELD_LO] == `FCE_BACKDOOR_ENABLE_FIELD_ON)
            secured_status_bit_r <= 1'b0;
        end
      end else if (arr_wr) begin
        if (arr_err) begin
          access_error_flag_r <= 1'b1;
          seq_r <= S_IDLE;
          seq_prog_r <= 1'b0;
          seq_data_r <= 1'b0;
        end else begin
          seq_r <= S_ARR;
          if (arr_is_data) seq_data_r <= 1'b1;
          else seq_prog_r <= 1'b1;
          if (seq_r == S_IDLE) begin
            seq_b0e_r <= ~arr_is_data & ~arr_addr[`FCE_BLK_BIT] & ~arr_addr[`FCE_ODD_BIT];
            seq_extra_r <= 1'b0;
            seq_page0_r <= (arr_addr[AW-1:12] == {(AW-12){1'b0}});
            seq_prot_r <= prot_r[sect];
          end else begin
            seq_extra_r <= 1'b1;
          end
          if (!arr_is_data && arr_addr == `FCE_SECW_OFS) sec_r <= arr_wdata;
        end
      end
      // ----- Register writes -----
      if (reg_wr) begin
        if (cmd_wr) begin
          if (seq_r != S_ARR || !valid_cmd(reg_wdata[7:0])) begin
            access_error_flag_r <= 1'b1;
            seq_r <= S_IDLE;
            seq_prog_r <= 1'b0;
            seq_data_r <= 1'b0;
          end else if (seq_prog_r && seq_data_r && reg_wdata[7:0] != `FCE_CMD_MERASE &&
                       reg_wdata[7:0] != `FCE_CMD_BLANK) begin
            access_error_flag_r <= 1'b1;
            seq_r <= S_IDLE;
            seq_prog_r <= 1'b0;
            seq_data_r <= 1'b0;
          end else if (prot_hit) begin
            protection_violation_flag_r <= 1'b1;
            seq_r <= S_IDLE;
            seq_prog_r <= 1'b0;
            seq_data_r <= 1'b0;
          end else begin
            cmd_r <= reg_wdata[7:0];
            seq_r <= S_CMD;
          end
        end else if (ustat_wr) begin
          // Sticky flags: write one to clear
          // sticky error flags
          if (reg_wdata[`FCE_US_ACCESS_ERROR_FLAG]) access_error_flag_r <= 1'b0;
          if (reg_wdata[`FCE_US_PROTECTION_VIOLATION_FLAG]) protection_violation_flag_r <= 1'b0;
          if (seq_r == S_CMD && reg_wdata[`FCE_US_COMMAND_BUFFER_EMPTY_FLAG] && !access_error_flag_r && !protection_violation_flag_r) begin
            run_cmd_r <= cmd_r;
            // buffer stays full for the whole run: nothing can be
            // queued behind a running command, so an array write is refused
            command_buffer_empty_flag_r <= 1'b0;
            command_complete_flag_r <= 1'b0;
            hv_en <= 1'b1;
            op_cnt_r <= 16'h0000;
            blank_ok_r <= reg_wdata[`FCE_US_BLANK];
            seq_r <= S_IDLE;
            seq_prog_r <= 1'b0;
            seq_data_r <= 1'b0;
          end else if (seq_r != S_IDLE && !reg_wdata[`FCE_US_COMMAND_BUFFER_EMPTY_FLAG]) begin
            access_error_flag_r <= 1'b1;
            seq_r <= S_IDLE;
            seq_prog_r <= 1'b0;
            seq_data_r <= 1'b0;
          end else if (seq_r == S_ARR) begin
            access_error_flag_r <= 1'b1;
            seq_r <= S_IDLE;
            seq_prog_r <= 1'b0;
            seq_data_r <= 1'b0;
          end
        end else if (seq_r != S_IDLE) begin
          // other register mid-sequence other register after command
          access_error_flag_r <= 1'b1;
          seq_r <= S_IDLE;
          seq_prog_r <= 1'b0;
          seq_data_r <= 1'b0;
        end else begin
          case (reg_addr)
            `FCE_A_MCR: key_access_bit_r <= reg_wdata[`FCE_MCR_KEY_ACCESS_BIT];
            `FCE_A_CLKD: begin
              clkd_r <= reg_wdata[7:0];
              clkd_ld_r <= 1'b1;
            end
            `FCE_A_SEC: begin
              sec_r <= reg_wdata;
              if (forced_sec_r && reg_wdata[`FCE_SECF_HI:`FCE_SECF_LO] == `FCE_SECF_OPEN) begin
                forced_sec_r <= 1'b0;
                secured_status_bit_r <= 1'b0;
              end
            end
            `FCE_A_PROT: prot_r <= reg_wdata[NSECT-1:0];
            default: ;
          endcase
        end
      end
      // Events win over a same-cycle clear
      if ((arr_wr && !key_access_bit_wr && arr_err) || (halt_rise && cmd_active)) access_error_flag_r <= 1'b1;
    end
  end

  // ==========================================================
  // Read data
  // Register read data is zero outside the slot after a read strobe
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
      arr_rdata <= 32'h0000_0000;
      secured <= 1'b1;
    end else begin
      secured <= secured_status_bit_r;
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `FCE_A_MCR: reg_rdata[`FCE_MCR_KEY_ACCESS_BIT] <= key_access_bit_r;
          `FCE_A_CLKD: reg_rdata <= {24'h000000, clkd_r};
          `FCE_A_SEC: reg_rdata <= {secured_status_bit_r, sec_r[30:0]};
          `FCE_A_PROT: reg_rdata[NSECT-1:0] <= prot_r;
          `FCE_A_USTAT: reg_rdata <= {24'h000000, command_buffer_empty_flag_r, command_complete_flag_r, protection_violation_flag_r, access_error_flag_r, 4'h0};
          `FCE_A_CMD: reg_rdata <= {24'h000000, cmd_r};
          `FCE_A_CTRL: reg_rdata <= {28'h0000000, key_lock_r, hv_en, seq_r};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
      // busy read: garbage, no error
      // Fixed pattern instead of array contents, so a busy read is easy to spot
      if (arr_rd) begin
        if (cmd_active) arr_rdata <= 32'hdead_beef;
        else arr_rdata <= {{(32-AW){1'b0}}, arr_addr};
      end
    end
  end

endmodule
`default_nettype wire

/* File: hw/fce_consts.vh */
// Constants for the flash command checker and security block
`ifndef FCE_CONSTS_VH
`define FCE_CONSTS_VH

// ==========================================================
// Register offsets (byte addresses, chosen)
`define FCE_A_MCR 8'h00
`define FCE_A_CLKD 8'h04
`define FCE_A_SEC 8'h08
`define FCE_A_PROT 8'h0c
`define FCE_A_USTAT 8'h10
`define FCE_A_CMD 8'h14
`define FCE_A_CTRL 8'h18

// ==========================================================
// Field positions
`define FCE_MCR_KEY_ACCESS_BIT 5
`define FCE_CLKD_DIVLD 7
`define FCE_US_COMMAND_BUFFER_EMPTY_FLAG 7
`define FCE_US_COMMAND_COMPLETE_FLAG 6
`define FCE_US_PROTECTION_VIOLATION_FLAG 5
`define FCE_US_ACCESS_ERROR_FLAG 4
`define FCE_US_BLANK 2
`define FCE_SEC_STAT 31
`define FCE_BACKDOOR_ENABLE_FIELD_HI 15
`define FCE_BACKDOOR_ENABLE_FIELD_LO 14
`define FCE_SECF_HI 1
`define FCE_SECF_LO 0
`define FCE_CTRL_HALT 0

// ==========================================================
// Command codes
`define FCE_CMD_BLANK 8'h05
`define FCE_CMD_PROG 8'h20
`define FCE_CMD_PERASE 8'h40
`define FCE_CMD_MERASE 8'h41
`define FCE_CMD_SIG 8'h65

// ==========================================================
// Values and array offsets
`define FCE_SECF_OPEN 2'b10
`define FCE_BACKDOOR_ENABLE_FIELD_ON 2'b10
`define FCE_KEY0_OFS 20'h00400
`define FCE_KEY1_OFS 20'h00404
`define FCE_SECW_OFS 20'h00414
`define FCE_ODD_BIT 2
`define FCE_BLK_BIT 19
`define FCE_SIZE_W 2'b10
`define FCE_SIZE_H 2'b01
`define FCE_OP_CYC 16'h0010

`endif

/* File: verification/fce_chk_sva.sv */
// Port assertions for the flash command checker and security block
`timescale 1ns/1ps
`default_nettype none
`include "fce_consts.vh"
module fce_chk #(parameter AW = 20) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic arr_rd,
  input wire logic [AW-1:0] arr_addr,
  input wire logic [31:0] arr_rdata,
  input wire logic halt_req,
  input wire logic hv_en,
  input wire logic secured
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Three cycles covers a registered edge detect on halt
  sequence halted_s;
    halt_req [*3];
  endsequence
  launch_src_a: assert property ($rose(hv_en) |-> $past(reg_wr && reg_addr == `FCE_A_USTAT && reg_wdata[7]))
    else $error("high voltage without launch write");
  halt_off_a: assert property (halted_s |-> !hv_en)
    else $error("high voltage on during halt");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  arr_busy_a: assert property (arr_rd && hv_en |=> arr_rdata == 32'hdead_beef)
    else $error("busy array read not flagged undefined");
  arr_idle_a: assert property (arr_rd && !hv_en |=> arr_rdata[AW-1:0] == $past(arr_addr))
    else $error("idle array read wrong");
  hv_len_a: assert property ($rose(hv_en) |-> ##[1:20] !hv_en)
    else $error("command never completes");
  sec_rst_a: assert property ($fell(sys_rst) |-> ##2 secured)
    else $error("not secured out of reset");
  sec_rise_a: assert property ($rose(secured) |-> $past(hv_en, 2) || $past(reg_wr, 2))
    else $error("secured rose without cause");
endmodule
bind fce_flash_cmd_error_security fce_chk #(.AW(AW)) chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .arr_rd(arr_rd), .arr_addr(arr_addr), .arr_rdata(arr_rdata), .halt_req(halt_req), .hv_en(hv_en),
  .secured(secured));
`default_nettype wire

/* File: verification/fce_bus_master.sv */
// Bus master model driving register and array accesses
`timescale 1ns/1ps
`default_nettype none
`include "fce_consts.vh"
module fce_bus_master (
  input wire logic clk_sys,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] arr_rdata,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic arr_wr,
  output logic arr_rd,
  output logic [19:0] arr_addr,
  output logic arr_is_data,
  output logic [1:0] arr_size,
  output logic [31:0] arr_wdata
);
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {arr_wr, arr_rd, arr_addr, arr_is_data, arr_size, arr_wdata} = '0;
  end
  // Data lines flip after use so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic aw(input logic [19:0] a, input logic [1:0] s, input logic dt, input logic [31:0] d);
    @(posedge clk_sys);
    {arr_addr, arr_size, arr_is_data, arr_wdata} <= {a, s, dt, d};
    arr_wr <= 1'b1;
    @(posedge clk_sys);
    arr_wr <= 1'b0;
    arr_wdata <= ~d;
  endtask
  task automatic ar(input logic [19:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    arr_addr <= a;
    arr_rd <= 1'b1;
    @(posedge clk_sys);
    arr_rd <= 1'b0;
    #1 d = arr_rdata;
  endtask
  // key words in order under key access
  task automatic keys(input logic [31:0] k0, input logic [31:0] k1);
    wr(`FCE_A_MCR, 32'h0000_0020);
    aw(`FCE_KEY0_OFS, `FCE_SIZE_W, 1'b0, k0);
    aw(`FCE_KEY1_OFS, `FCE_SIZE_W, 1'b0, k1);
    wr(`FCE_A_MCR, 32'h0000_0000);
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_flash_cmd_error_security.sv */
// Self-checking bench for the flash command checker and security block
`timescale 1ns/1ps
`default_nettype none
`include "fce_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("Error %0t: got %h want %h", $time, g, e); end end
module tb_flash_cmd_error_security;
  localparam logic [31:0] KEY_W = 32'h1234_5678;
  localparam logic [23:0] CODES = {`FCE_CMD_PERASE, `FCE_CMD_MERASE, `FCE_CMD_SIG};
  logic clk_sys, sys_rst, halt_req, reg_wr, reg_rd, arr_wr, arr_rd, arr_is_data, hv_en, secured;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, arr_wdata, arr_rdata, d;
  logic [19:0] arr_addr;
  logic [1:0] arr_size;
  int n_errors = 0;
  int compares = 0;
  // Key enable set, field left secured
  fce_flash_cmd_error_security #(.SEC_WORD_DFLT(32'h0000_8000), .KEY_DFLT({KEY_W, KEY_W})) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arr_wr(arr_wr), .arr_rd(arr_rd), .arr_addr(arr_addr),
    .arr_is_data(arr_is_data), .arr_size(arr_size), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata),
    .halt_req(halt_req), .hv_en(hv_en), .secured(secured));
  fce_bus_master m_u (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .arr_rdata(arr_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .arr_wr(arr_wr), .arr_rd(arr_rd),
    .arr_addr(arr_addr), .arr_is_data(arr_is_data), .arr_size(arr_size), .arr_wdata(arr_wdata));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK(secured, 1'b1)
    m_u.rd(`FCE_A_SEC, d);
    `CHK(d, 32'h8000_8000)
  endtask
  // Expect {complete, protection, access} status bits, then clear
  task automatic err(input logic [2:0] e);
    m_u.rd(`FCE_A_USTAT, d);
    `CHK(d[6:4], e)
    m_u.wr(`FCE_A_USTAT, 32'h0000_0030);
  endtask
  task automatic launch(input logic [7:0] c, input logic [31:0] s);
    m_u.aw(20'h00100, `FCE_SIZE_W, 1'b0, 32'h0000_0001);
    m_u.wr(`FCE_A_CMD, {24'h0, c});
    m_u.wr(`FCE_A_USTAT, s);
  endtask
  task automatic idle_wait();
    @(posedge clk_sys);
    for (int i = 0; i < 40 && hv_en !== 1'b0; i++) @(posedge clk_sys);
    `CHK(hv_en, 1'b0)
  endtask
  task automatic bad(input int n);
    if (n < 2) m_u.aw(20'h00000, `FCE_SIZE_H, n[0], 32'h0);
    else m_u.aw(20'h00000, `FCE_SIZE_W, 1'b0, 32'h0);
    case (n)
      1: m_u.aw(20'h00002, `FCE_SIZE_H, 1'b1, 32'h0);
      2: m_u.aw(20'h00000, `FCE_SIZE_H, 1'b1, 32'h0);
      3: m_u.wr(`FCE_A_CMD, 32'h0000_0033);
      4: m_u.wr(`FCE_A_CLKD, 32'h0000_0001);
      5: m_u.aw(20'h00008, `FCE_SIZE_W, 1'b0, 32'h0);
      default: m_u.wr(`FCE_A_CMD, 32'h0000_0040);
    endcase
    case (n)
      2, 6: m_u.wr(`FCE_A_CMD, 32'h0000_0040);
      7: m_u.wr(`FCE_A_USTAT, 32'h0000_0000);
      8: m_u.wr(`FCE_A_PROT, 32'h0000_0000);
      default: ;
    endcase
    err(3'b101);
  endtask
  initial begin
    #300000;
    n_errors++;
    stop_test();
  end
  initial begin
    sys_rst = 1'b1;
    halt_req = 1'b0;
    do_reset();
    m_u.aw(20'h00100, `FCE_SIZE_W, 1'b0, 32'h0);
    err(3'b101);
    m_u.wr(`FCE_A_CLKD, 32'h0000_0001);
    m_u.wr(`FCE_A_PROT, 32'h0000_0000);
    for (int n = 0; n < 9; n++) bad(n);
    for (int k = 0; k < 3; k++) begin
      launch(CODES[8*k +: 8], 32'h0000_0080);
      repeat (2) @(posedge clk_sys);
      `CHK(hv_en, 1'b1)
      m_u.ar(20'h00100, d);
      `CHK(d, 32'hdead_beef)
      idle_wait();
      m_u.ar(20'h00100, d);
      `CHK(d, 32'h0000_0100)
      err(3'b100);
    end
    launch(8'h40, 32'h0000_0080);
    m_u.aw(20'h00104, `FCE_SIZE_W, 1'b0, 32'h0);
    idle_wait();
    err(3'b101);
    m_u.wr(`FCE_A_PROT, 32'h0000_00ff);
    launch(8'h41, 32'h0000_0080);
    err(3'b110);
    launch(8'h40, 32'h0000_0080);
    `CHK(hv_en, 1'b0)
    m_u.aw(20'h00000, `FCE_SIZE_H, 1'b0, 32'h0);
    m_u.wr(`FCE_A_PROT, 32'h0000_0000);
    launch(8'h40, 32'h0000_0080);
    repeat (2) @(posedge clk_sys);
    `CHK(hv_en, 1'b0)
    err(3'b111);
    err(3'b101);
    launch(8'h40, 32'h0000_0080);
    repeat (3) @(posedge clk_sys);
    halt_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK(hv_en, 1'b0)
    err(3'b101);
    halt_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
    halt_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    err(3'b100);
    halt_req <= 1'b0;
    m_u.keys(KEY_W, KEY_W);
    repeat (2) @(posedge clk_sys);
    `CHK(secured, 1'b0)
    m_u.rd(`FCE_A_SEC, d);
    `CHK(d, 32'h0000_8000)
    do_reset();
    m_u.keys(32'h0000_0000, 32'h0000_0000);
    m_u.keys(KEY_W, KEY_W);
    repeat (2) @(posedge clk_sys);
    `CHK(secured, 1'b1)
    do_reset();
    m_u.wr(`FCE_A_CLKD, 32'h0000_0001);
    launch(`FCE_CMD_MERASE, 32'h0000_0080);
    idle_wait();
    launch(`FCE_CMD_BLANK, 32'h0000_0084);
    idle_wait();
    repeat (2) @(posedge clk_sys);
    `CHK(secured, 1'b0)
    m_u.aw(`FCE_SECW_OFS, `FCE_SIZE_W, 1'b0, 32'h0000_8002);
    m_u.wr(`FCE_A_CMD, {24'h0, `FCE_CMD_PROG});
    m_u.wr(`FCE_A_USTAT, 32'h0000_0080);
    idle_wait();
    m_u.rd(`FCE_A_SEC, d);
    `CHK(d, 32'h0000_8002)
    launch(`FCE_CMD_MERASE, 32'h0000_0080);
    idle_wait();
    repeat (2) @(posedge clk_sys);
    `CHK(secured, 1'b1)
    m_u.wr(`FCE_A_SEC, 32'h0000_8002);
    repeat (2) @(posedge clk_sys);
    `CHK(secured, 1'b0)
    do_reset();
    stop_test();
  end
endmodule
`default_nettype wire
